// File: shared_pwm_regs.vh
// register offsets, field positions and reset values of the shared timebase pwm
`ifndef SHARED_PWM_REGS_VH
`define SHARED_PWM_REGS_VH
// register indices; the byte address on the bus is index * 4
`define IDX_DUTY3       12'h314
`define IDX_CTRL3       12'h316
`define IDX_DUTY4       12'h318
`define IDX_CTRL4       12'h31a
`define IDX_TMR_COUNT   12'h31c
`define IDX_TMR_LIMIT   12'h31d
`define IDX_TMR_CTRL    12'h31e
`define IDX_TMR_CLKSEL  12'h31f
`define IDX_FLAG        12'h320
`define IDX_PIN_DIR     12'h321
`define IDX_PIN_ROUTE   12'h322
// channel control fields
`define CTL_EN_BIT      7
`define CTL_OUT_BIT     5
`define CTL_POL_BIT     4
// duty register fields
`define DUTY_HI_MSB     15
`define DUTY_HI_LSB     8
`define DUTY_LO_MSB     7
`define DUTY_LO_LSB     6
// timer control fields
`define TCTL_ON_BIT     7
`define TCTL_PS_MSB     6
`define TCTL_PS_LSB     4
// clock select value for system clock divided by four
`define CLKSEL_FOSC4    4'h1
// reset values
`define RST_LIMIT       8'hff
`define RST_CTRL        8'h00
`define RST_PIN_DIR     2'h3
`define RST_PIN_ROUTE   2'h3
`endif

// File: shared_timebase_pwm.v
// two-channel 10-bit pwm on a shared period timer with apb register access
`timescale 1ns/1ps
`default_nettype none
`include "shared_pwm_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - each channel makes a 10-bit resolution output from the shared timer
// - one shared period for all channels; each duty value is independent
// - outputs go active when the timer count clears to zero
// - output goes inactive when 10-bit time base equals the duty value
// - duty at or above 4*(period register value+1) never clears output
// - duty registers double-buffered, loaded at the period match
// - polarity bit inverts the channel output
// - period is (limit+1) times four clocks times prescale
// - after match: clear count, set output unless duty zero, latch buffers
// - postscaler has no effect on the pwm
// - duty is high register eight bits plus low register bits 7:6
// - duty registers writable whenever clk_en is high; take effect at next period
// - active pulse width is duty times clock period times prescale
// - time base joins 8-bit count with two low sub-count bits
// - resolution reaches ten bits when period limit is 255
// - pulse-width value above period leaves pins unchanged
// - in sleep timer stops, state and pin level are held
// - any reset restores registers and forces pins to input
// - output frequency scales directly with the system clock
// - outputs muxed with port latch; direction bit clear lets pwm drive
// - channel makes its waveform only while its enable bit is set
// - read-only output bit returns the channel's current level
module shared_timebase_pwm (
  input  wire        core_clk,
  input  wire        sys_rst,
  input  wire        clk_en,
  input  wire        sleep,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [13:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire [1:0]  port_latch,
  output reg  [1:0]  pin_out,
  output reg  [1:0]  pin_oe,
  output wire        timer_match_pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  reg  [7:0] period_timer_count_ff;
  reg  [1:0] sub_count_ff;
  reg  [7:0] prescale_cnt_ff;
  reg  [7:0] period_limit_reg_ff;
  reg  [7:0] period_timer_control_ff;
  reg  [3:0] period_timer_clock_select_ff;
  reg        timer_overflow_flag_ff;
  reg  [1:0] pin_direction_bit_ff;
  reg  [1:0] pin_route_select_ff;
  reg  [9:0] duty_value_reg_ff [0:1];
  reg  [9:0] duty_buf_ff [0:1];
  reg  [7:0] channel_control_reg_ff [0:1];
  reg  [1:0] raw_out_ff;

  wire       run;
  wire       tmr_on;
  wire [7:0] ps_max;
  wire       ps_tick;
  wire       tick;
  wire       at_limit;
  wire       wrap;
  wire [9:0] time_base;
  wire       wr_en;
  wire       rd_en;
  wire [11:0] idx;
  wire       idx_mapped;
  wire [9:0] duty_wr;
  wire [1:0] ch_pol;
  wire [1:0] ch_level;

  // prescale code to divide-minus-one: 1,2,4,...,128
  function [7:0] ps_div;
    input [2:0] code;
    begin
      case (code)
        3'h0:    ps_div = 8'h00;
        3'h1:    ps_div = 8'h01;
        3'h2:    ps_div = 8'h03;
        3'h3:    ps_div = 8'h07;
        3'h4:    ps_div = 8'h0f;
        3'h5:    ps_div = 8'h1f;
        3'h6:    ps_div = 8'h3f;
        default: ps_div = 8'h7f;
      endcase
    end
  endfunction

  // 10-bit compare level for one channel; duty at/over 4*(limit+1) stays on
  function next_level;
    input       cur;
    input [9:0] duty;
    input [9:0] tb;
    begin
      if (duty >= {period_limit_reg_ff, 2'h3} + 10'h001 && period_limit_reg_ff != 8'hff)
        next_level = cur;
      else if (tb == duty)
        next_level = 1'b0;
      else
        next_level = cur;
    end
  endfunction

  // index decode; the odd holes between channel registers are unmapped
  function idx_is_mapped;
    input [11:0] ix;
    begin
      case (ix)
        `IDX_DUTY3, `IDX_CTRL3, `IDX_DUTY4, `IDX_CTRL4,
        `IDX_TMR_COUNT, `IDX_TMR_LIMIT, `IDX_TMR_CTRL, `IDX_TMR_CLKSEL,
        `IDX_FLAG, `IDX_PIN_DIR, `IDX_PIN_ROUTE: idx_is_mapped = 1'b1;
        default:                                 idx_is_mapped = 1'b0;
      endcase
    end
  endfunction

  // bus word to 10-bit duty: high byte, then bits 7:6
  function [9:0] duty_from_word;
    input [31:0] w;
    begin
      duty_from_word = {w[`DUTY_HI_MSB:`DUTY_HI_LSB], w[`DUTY_LO_MSB:`DUTY_LO_LSB]};
    end
  endfunction

  // 10-bit duty back into the bus word layout
  function [31:0] duty_to_word;
    input [9:0] d;
    begin
      duty_to_word = {16'h0000, d[9:2], d[1:0], 6'h00};
    end
  endfunction

  // control read view: live channel level, after polarity, shown in the read-only bit
  function [31:0] ctrl_to_word;
    input [7:0] c;
    input       lvl;
    begin
      ctrl_to_word = {24'h000000, c[7:6], lvl, c[4:0]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states
  assign pready  = 1'b1;
  assign idx     = paddr[13:2];
  assign wr_en   = psel & penable & pwrite & clk_en;
  assign rd_en   = psel & ~penable & ~pwrite;
  assign idx_mapped = idx_is_mapped(idx);
  assign duty_wr    = duty_from_word(pwdata);
  assign pslverr    = psel & penable & ~idx_mapped;
  assign ch_pol     = {channel_control_reg_ff[1][`CTL_POL_BIT], channel_control_reg_ff[0][`CTL_POL_BIT]};
  assign ch_level   = raw_out_ff ^ ch_pol;

  // sleep freezes everything counting; clk_en freezes all state
  assign run      = clk_en & ~sleep;
  assign tmr_on   = period_timer_control_ff[`TCTL_ON_BIT];
  assign ps_max   = ps_div(period_timer_control_ff[`TCTL_PS_MSB:`TCTL_PS_LSB]);
  assign ps_tick  = (prescale_cnt_ff == ps_max);
  // sub-count steps each system clock at 1:1, else each prescale step
  assign tick     = run & tmr_on & ps_tick;
  assign time_base = {period_timer_count_ff, sub_count_ff};
  assign at_limit = (period_timer_count_ff == period_limit_reg_ff);
  assign wrap     = tick & at_limit & (sub_count_ff == 2'h3);
  // postscaler not modelled: it never reaches the pwm path
  assign timer_match_pulse = wrap;

  ////////////////////////////////////////////////////////////////////////////
  // shared timer
  always @(posedge core_clk) begin
    if (sys_rst) begin
      period_timer_count_ff <= 8'h00;
      sub_count_ff          <= 2'h0;
      prescale_cnt_ff       <= 8'h00;
    end else if (run && tmr_on) begin
      prescale_cnt_ff <= ps_tick ? 8'h00 : prescale_cnt_ff + 8'h01;
      if (tick) begin
        sub_count_ff <= sub_count_ff + 2'h1;
        if (sub_count_ff == 2'h3) begin
          period_timer_count_ff <= at_limit ? 8'h00 : period_timer_count_ff + 8'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channels
  integer i;
  always @(posedge core_clk) begin
    if (sys_rst) begin
      raw_out_ff     <= 2'h0;
      duty_buf_ff[0] <= 10'h000;
      duty_buf_ff[1] <= 10'h000;
    end else if (run) begin
      for (i = 0; i < 2; i = i + 1) begin
        if (wrap) begin
          duty_buf_ff[i] <= duty_value_reg_ff[i];
          // disabled channel stays inactive and restarts only here
          raw_out_ff[i]  <= channel_control_reg_ff[i][`CTL_EN_BIT] &&
                            (duty_value_reg_ff[i] != 10'h000);
        end else if (!channel_control_reg_ff[i][`CTL_EN_BIT]) begin
          raw_out_ff[i]  <= 1'b0;
        end else if (tick) begin
          // compare against the value the time base is about to show
          raw_out_ff[i]  <= next_level(raw_out_ff[i], duty_buf_ff[i], time_base + 10'h001);
        end
      end
    end
  end

  // pin mux: polarity, port latch, direction
  // unrolled so the loop index keeps a single driver
  always @* begin
    pin_out[0] = pin_route_select_ff[0] ? ch_level[0] : port_latch[0];
    pin_out[1] = pin_route_select_ff[1] ? ch_level[1] : port_latch[1];
    pin_oe     = ~pin_direction_bit_ff;
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  always @(posedge core_clk) begin
    if (sys_rst) begin
      period_limit_reg_ff          <= `RST_LIMIT;
      period_timer_control_ff      <= `RST_CTRL;
      period_timer_clock_select_ff <= `CLKSEL_FOSC4;
      timer_overflow_flag_ff       <= 1'b0;
      pin_direction_bit_ff         <= `RST_PIN_DIR;
      pin_route_select_ff          <= `RST_PIN_ROUTE;
      channel_control_reg_ff[0]    <= `RST_CTRL;
      channel_control_reg_ff[1]    <= `RST_CTRL;
      duty_value_reg_ff[0]         <= 10'h000;
      duty_value_reg_ff[1]         <= 10'h000;
    end else if (clk_en) begin
      // set wins over a same-cycle software clear
      if (wrap)
        timer_overflow_flag_ff <= 1'b1;
      else if (wr_en && idx == `IDX_FLAG && !pwdata[0])
        timer_overflow_flag_ff <= 1'b0;
      if (wr_en) begin
        case (idx)
          `IDX_DUTY3:      duty_value_reg_ff[0] <= duty_wr;
          `IDX_DUTY4:      duty_value_reg_ff[1] <= duty_wr;
          `IDX_CTRL3:      channel_control_reg_ff[0] <= pwdata[7:0] & 8'h90;
          `IDX_CTRL4:      channel_control_reg_ff[1] <= pwdata[7:0] & 8'h90;
          `IDX_TMR_LIMIT:  period_limit_reg_ff <= pwdata[7:0];
          `IDX_TMR_CTRL:   period_timer_control_ff <= pwdata[7:0];
          `IDX_TMR_CLKSEL: period_timer_clock_select_ff <= pwdata[3:0];
          `IDX_PIN_DIR:    pin_direction_bit_ff <= pwdata[1:0];
          `IDX_PIN_ROUTE:  pin_route_select_ff <= pwdata[1:0];
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads, captured in setup phase
  always @(posedge core_clk) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
    end else if (rd_en && clk_en) begin
      case (idx)
        `IDX_DUTY3:      prdata <= duty_to_word(duty_value_reg_ff[0]);
        `IDX_DUTY4:      prdata <= duty_to_word(duty_value_reg_ff[1]);
        `IDX_CTRL3:      prdata <= ctrl_to_word(channel_control_reg_ff[0], ch_level[0]);
        `IDX_CTRL4:      prdata <= ctrl_to_word(channel_control_reg_ff[1], ch_level[1]);
        `IDX_TMR_COUNT:  prdata <= {24'h000000, period_timer_count_ff};
        `IDX_TMR_LIMIT:  prdata <= {24'h000000, period_limit_reg_ff};
        `IDX_TMR_CTRL:   prdata <= {24'h000000, period_timer_control_ff};
        `IDX_TMR_CLKSEL: prdata <= {28'h0000000, period_timer_clock_select_ff};
        `IDX_FLAG:       prdata <= {31'h00000000, timer_overflow_flag_ff};
        `IDX_PIN_DIR:    prdata <= {30'h00000000, pin_direction_bit_ff};
        `IDX_PIN_ROUTE:  prdata <= {30'h00000000, pin_route_select_ff};
        default:         prdata <= 32'h00000000;
      endcase
    end
  end

endmodule // shared_timebase_pwm
`default_nettype wire

// File: pwm_port_checker_assertions.sv
// port-level assertions for the shared timebase pwm
`timescale 1ns/1ps
`default_nettype none
`include "shared_pwm_regs.vh"
module pwm_port_checker (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        clk_en,
  input wire logic        sleep,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic [1:0]  port_latch,
  input wire logic [1:0]  pin_out,
  input wire logic [1:0]  pin_oe,
  input wire logic        timer_match_pulse
);
  logic acc;
  logic mapped;
  assign acc = psel && penable;
  assign mapped = paddr[13:2] inside {`IDX_DUTY3, `IDX_CTRL3, `IDX_DUTY4, `IDX_CTRL4, [`IDX_TMR_COUNT:`IDX_PIN_ROUTE]};
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////////
  chk_reset_input: assert property ($fell(sys_rst) |-> pin_oe == 2'b00)
    else $error("pins not input after reset");
  chk_oe_by_write: assert property ($changed(pin_oe) |-> $past(acc && pwrite && clk_en))
    else $error("pin enable moved without a write");
  chk_err_unmapped: assert property (acc && !mapped |-> pslverr)
    else $error("unmapped access not refused");
  chk_err_mapped: assert property (acc && mapped |-> !pslverr)
    else $error("mapped access refused");
  chk_err_phase: assert property (pslverr |-> acc)
    else $error("error outside access phase");
  // prdata only moves at a setup edge, so stale reads stay stable
  chk_prdata_hold: assert property (!$past(psel && !penable) |-> $stable(prdata))
    else $error("read data moved without a setup");
  chk_pulse_spacing: assert property (timer_match_pulse && clk_en && !sleep |=> !timer_match_pulse[*3])
    else $error("period shorter than four clocks");
  chk_sleep_pin: assert property ($past(sleep) && !$past(psel) && $stable(port_latch) |-> $stable(pin_out))
    else $error("pin moved during sleep");
  chk_sleep_tick: assert property (sleep && $past(sleep) |-> !$rose(timer_match_pulse))
    else $error("timer wrapped during sleep");
  cover property (timer_match_pulse);
  cover property (pslverr);
  cover property (sleep ##1 !sleep);
endmodule // pwm_port_checker
bind shared_timebase_pwm pwm_port_checker u_pwm_port_checker (.core_clk(core_clk), .sys_rst(sys_rst),
  .clk_en(clk_en), .sleep(sleep), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pslverr(pslverr), .port_latch(port_latch), .pin_out(pin_out), .pin_oe(pin_oe),
  .timer_match_pulse(timer_match_pulse));
`default_nettype wire

// File: pwm_load.sv
// load on the two pwm pins: resolves the pin level and times pulses
`timescale 1ns/1ps
`default_nettype none
module pwm_load (
  input wire logic  core_clk,
  input wire logic  [1:0] pin_out,
  input wire logic  [1:0] pin_oe,
  output wire logic [1:0] pin_level,
  output var int    high_len [2],
  output var int    per_len [2]
);
  int   cyc;
  int   rise_t [2];
  logic [1:0] prev = 2'h0;
  // pull-down: an undriven pin reads low
  assign pin_level = pin_out & pin_oe;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    prev <= pin_level;
    for (int i = 0; i < 2; i++) begin
      if (pin_level[i] && !prev[i]) begin
        per_len[i] <= cyc - rise_t[i];
        rise_t[i] <= cyc;
      end
      if (!pin_level[i] && prev[i]) high_len[i] <= cyc - rise_t[i];
    end
  end
endmodule // pwm_load
`default_nettype wire

// File: shared_timebase_pwm_bench.sv
// self-checking bench for the shared timebase pwm
`timescale 1ns/1ps
`default_nettype none
`include "shared_pwm_regs.vh"
module shared_timebase_pwm_bench;
  logic core_clk = 0, sys_rst = 1, clk_en = 1, sleep = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h0, rdat, cnt;
  logic [1:0]  port_latch = 2'h2, hi_any, hi_all;
  wire         pready, pslverr, tick;
  wire  [31:0] prdata;
  wire  [1:0]  pin_out, pin_oe, lvl;
  int          high_len [2], per_len [2];
  int          num_errors = 0, checked = 0;
  always #2.5 core_clk = ~core_clk;
  shared_timebase_pwm u_shared_timebase_pwm (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .sleep(sleep), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .port_latch(port_latch), .pin_out(pin_out),
    .pin_oe(pin_oe), .timer_match_pulse(tick));
  pwm_load u_pwm_load (.core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_level(lvl),
    .high_len(high_len), .per_len(per_len));
  ////////////////////////////////////////////////////////////////////////////////
  task end_of_test;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task xfer(input logic w, input logic [11:0] idx, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1; pwrite <= w; paddr <= {idx, 2'b00}; pwdata <= d; penable <= 0;
    @(posedge core_clk);
    penable <= 1;
    n = 0;
    do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin chk("pready", 1, pready); end_of_test; end
    rdat = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wr(input logic [11:0] idx, input logic [31:0] d); xfer(1, idx, d); endtask
  task rd(input string nm, input logic [11:0] idx, input logic [31:0] exp); xfer(0, idx, 0); chk(nm, exp, rdat); endtask
  task dly(input int n); repeat (n) @(posedge core_clk); endtask
  task watch(input int n);
    hi_any = 0;
    hi_all = 2'h3;
    repeat (n) begin @(negedge core_clk); hi_any |= lvl; hi_all &= lvl; end
  endtask
  task wait_tick;
    int n;
    n = 0;
    do begin @(negedge core_clk); n++; end while (tick !== 1'b1 && n < 200);
    if (n >= 200) begin chk("tick", 1, 0); end_of_test; end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    dly(10); sys_rst <= 0; dly(1);
    chk("pin_oe", 0, pin_oe);
    rd("limit", `IDX_TMR_LIMIT, 32'hff);
    rd("pin_dir", `IDX_PIN_DIR, 32'h3);
    rd("ctrl3", `IDX_CTRL3, 32'h0);
    xfer(0, 12'h317, 0); chk("unmapped err", 1, err); chk("unmapped data", 0, rdat);
    wr(`IDX_CTRL3, 0); wr(`IDX_TMR_LIMIT, 3); wr(`IDX_DUTY3, 32'h140); wr(`IDX_DUTY4, 32'h400);
    wr(`IDX_FLAG, 0); wr(`IDX_TMR_CLKSEL, `CLKSEL_FOSC4); wr(`IDX_TMR_CTRL, 32'h80);
    wait_tick;
    rd("flag set", `IDX_FLAG, 32'h1);
    wr(`IDX_PIN_DIR, 0); wr(`IDX_CTRL3, 32'h80); wr(`IDX_CTRL4, 32'h80);
    dly(64); chk("high3", 5, high_len[0]);
    chk("period3", 16, per_len[0]);
    watch(20); chk("full on", 1, hi_all[1]);
    rd("ctrl4 out", `IDX_CTRL4, 32'ha0);
    wait_tick; wr(`IDX_DUTY3, 32'h240); dly(4);
    @(negedge core_clk);
    chk("old level", 0, lvl[0]);
    chk("old duty", 5, high_len[0]);
    dly(40); chk("new duty", 9, high_len[0]);
    wr(`IDX_CTRL3, 0); dly(2); watch(20); chk("off", 0, hi_any[0]);
    wr(`IDX_CTRL3, 32'h10); dly(2); watch(20); chk("off inv", 1, hi_all[0]);
    wr(`IDX_DUTY3, 0); wr(`IDX_CTRL3, 32'h80); dly(40); watch(20); chk("zero", 0, hi_any[0]);
    wr(`IDX_CTRL3, 32'h90); dly(40); watch(20); chk("zero inv", 1, hi_all[0]);
    wr(`IDX_DUTY4, 32'h240);
    wr(`IDX_TMR_CTRL, 32'ha0);
    dly(240);
    chk("high4 ps4", 36, high_len[1]);
    chk("period4 ps4", 64, per_len[1]);
    sleep <= 1; xfer(0, `IDX_TMR_COUNT, 0); cnt = rdat; dly(40);
    rd("count held", `IDX_TMR_COUNT, cnt);
    sleep <= 0; wait_tick;
    wr(`IDX_PIN_ROUTE, 0); dly(1); chk("latch", port_latch, pin_out);
    port_latch <= 2'h1;
    dly(1);
    chk("latch flip", 2'h1, pin_out);
    clk_en <= 0;
    wr(`IDX_TMR_LIMIT, 32'h9);
    clk_en <= 1;
    rd("limit frozen", `IDX_TMR_LIMIT, 32'h3);
    sys_rst <= 1; dly(3); sys_rst <= 0; dly(1); chk("oe reset", 0, pin_oe);
    rd("limit reset", `IDX_TMR_LIMIT, 32'hff);
    end_of_test;
  end
endmodule // shared_timebase_pwm_bench
`default_nettype wire
